// File: msw_asserts.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// port checker of the light switch
module msw_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // avalon slave
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // pins and outputs
  input wire logic        trigPin,
  input wire logic        clearPin,
  input wire logic        swOut,
  input wire logic        contMode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // any bus request
  wire logic req = avs_read || avs_write;
  // bus: one wait cycle, then high again
  a_wait_one_cycle: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_wait_short_low: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_idle_wait_high: assert property (!req |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  a_cmd_reads_zero: assert property (avs_read && !avs_waitrequest &&
    (avs_address == msw_pkg::OFF_CMD || avs_address == 6'h24) |-> avs_readdata == 32'h0)
    else $error("command or unmapped place read not zero");
  // switch behaviour
  a_clear_forces_off: assert property (clearPin [*6] |=> !swOut && !contMode)
    else $error("output on while clear held");
  a_cont_keeps_out: assert property (contMode |-> swOut)
    else $error("output low in continuous light");
  a_cont_retrig_off: assert property (contMode && $rose(trigPin) |-> ##[1:8] !swOut)
    else $error("trigger in continuous light did not turn off");
  a_cont_needs_trig: assert property ($rose(contMode) |-> $past(trigPin, 2) ||
    $past(trigPin, 3) || $past(trigPin, 4) || $past(trigPin, 5))
    else $error("continuous light without a held trigger");
  // main scenarios
  c_cont: cover property ($rose(contMode));
  c_off: cover property ($fell(swOut) && !contMode);
  c_access: cover property (req && !avs_waitrequest);
endmodule : msw_asserts

bind msw_light_switch msw_asserts u_chk (.clk, .reset_n, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .trigPin, .clearPin, .swOut, .contMode);
`default_nettype wire

// File: msw_light_switch.sv
// How it works
// R1: a rising edge on the trigger pin turns the switch output on.
// R2: a trigger held for the continuous hold time from the off state latches continuous light.
// R3: a trigger released before the hold time starts the off delay, keeping the time counted.
// R4: the output goes off when the elapsed time reaches the off delay.
// R5: with pre-warning on, the output drops for the warn length from off delay minus warn start.
// R6: a new trigger edge while on clears the elapsed time and turns the output off.
// R7: the clear pin or command zeroes the elapsed time and turns the output off.
// R8: the off-delay value sets when the output falls after a timed pulse begins.
// R9: the hold value sets how long the trigger must stay high for continuous light.
// R10: warn start places the pre-warning and warn length sets how long it lasts.
// R11: software gives off delay, warn start and warn length in one common time base.
// R12: after power returns, state is kept when retentive and cleared otherwise.
// R13: each timing value may come from another function's live value instead of a register.
// R14: the elapsed time advances once per time-base tick while running and is zero otherwise.
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module msw_light_switch #(
  parameter logic [31:0] TICK_DIV_INIT = msw_pkg::TICK_DIV_RST
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // avalon-mm slave
  input  wire logic [5:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  // asynchronous pins
  input  wire logic                 trigPin,
  input  wire logic                 clearPin,
  input  wire logic                 powerRestorePin,
  // live values of other functions, same clock
  input  wire msw_pkg::msw_times_s  extTimes,
  // switch outputs
  output logic                      swOut,
  output logic                      contMode
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and time base

  logic [2:0] pinSync;
  logic       tick;

  msw_sync #(
    .WIDTH    (3)
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .pinAsync ({powerRestorePin, clearPin, trigPin}),
    .pinSync  (pinSync)
  );

  logic [31:0] tickDiv_r;

  msw_tick u_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .divisor (tickDiv_r),
    .tick    (tick)
  );

  // synchronised levels; the two clocks of latency are far below one tick,
  // so they never show in the timing
  wire trigLvl  = pinSync[0];
  wire clearLvl = pinSync[1];
  wire pwrLvl   = pinSync[2];

  //////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [31:0]         ctrl_r;
  logic [31:0]         offDelay_r;
  logic [31:0]         hold_r;
  logic [31:0]         pwStart_r;
  logic [31:0]         pwLen_r;
  logic [31:0]         elapsed_r;
  logic [31:0]         elapsed_nxt;
  msw_pkg::msw_state_e state_r;
  msw_pkg::msw_state_e state_nxt;
  logic                trigPrev_r;
  logic                pwrPrev_r;
  logic                swOut_r;
  logic                contMode_r;
  logic                waitReq_r;
  logic [31:0]         readData_r;

  //////////////////////////////////////////////////////////////////////////////
  // bus decode
  // every access gets exactly one wait cycle: the request is seen with
  // waitrequest high, waitrequest drops for one clock, and the write lands
  // and the read data are taken at the edge that ends that clock

  wire writeHit = avs_write && !waitReq_r;
  wire selCtrl  = (avs_address == msw_pkg::OFF_CTRL);
  wire selOff   = (avs_address == msw_pkg::OFF_OFF_DELAY);
  wire selHold  = (avs_address == msw_pkg::OFF_HOLD);
  wire selPws   = (avs_address == msw_pkg::OFF_PW_START);
  wire selPwl   = (avs_address == msw_pkg::OFF_PW_LEN);
  wire selDiv   = (avs_address == msw_pkg::OFF_TICK_DIV);
  wire selStat  = (avs_address == msw_pkg::OFF_STATUS);
  wire selElap  = (avs_address == msw_pkg::OFF_ELAPSED);
  wire selCmd   = (avs_address == msw_pkg::OFF_CMD);

  // byte lane mask from byteenable
  wire [31:0] beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // merged write values per register
  wire [31:0] ctrlWr = (ctrl_r & ~beMask) | (avs_writedata & beMask);
  wire [31:0] offWr  = (offDelay_r & ~beMask) | (avs_writedata & beMask);
  wire [31:0] holdWr = (hold_r & ~beMask) | (avs_writedata & beMask);
  wire [31:0] pwsWr  = (pwStart_r & ~beMask) | (avs_writedata & beMask);
  wire [31:0] pwlWr  = (pwLen_r & ~beMask) | (avs_writedata & beMask);
  wire [31:0] divWr  = (tickDiv_r & ~beMask) | (avs_writedata & beMask);

  // command pulses, low byte only
  wire cmdHit   = writeHit && selCmd && avs_byteenable[0];
  wire cmdClear = cmdHit && avs_writedata[msw_pkg::CMD_CLEAR];
  wire cmdPwr   = cmdHit && avs_writedata[msw_pkg::CMD_PWR_RET];

  // one write strobe per register, only at the acknowledging edge;
  // status and elapsed have no strobe, so writes there drop; command writes only make the pulses above
  wire wrCtrl = writeHit && selCtrl;
  wire wrOff  = writeHit && selOff;
  wire wrHold = writeHit && selHold;
  wire wrPws  = writeHit && selPws;
  wire wrPwl  = writeHit && selPwl;
  wire wrDiv  = writeHit && selDiv;

  //////////////////////////////////////////////////////////////////////////////
  // timing value selection

  wire pwEn   = ctrl_r[msw_pkg::CTRL_PW_EN];
  wire retain = ctrl_r[msw_pkg::CTRL_RETAIN];

  // a live value from another function may change at any clock and is used
  // as it stands; if it shrinks below the elapsed time, the greater-or-equal
  // compare ends the delay at once instead of letting the count run on
  // up to the saturation of the 32-bit counter
  // each value from register or from another function's live value
  wire [31:0] tOff  = ctrl_r[msw_pkg::CTRL_SRC_OFF] ? extTimes.offDelay : offDelay_r; // R13 R8
  wire [31:0] tHold = ctrl_r[msw_pkg::CTRL_SRC_HLD] ? extTimes.hold     : hold_r;     // R13 R9
  wire [31:0] tPws  = ctrl_r[msw_pkg::CTRL_SRC_PWS] ? extTimes.pwStart  : pwStart_r;  // R13 R10
  wire [31:0] tPwl  = ctrl_r[msw_pkg::CTRL_SRC_PWL] ? extTimes.pwLen    : pwLen_r;    // R13 R10

  // warn window, all values in the same tick units
  // a warning start above the off delay clamps to zero instead of wrapping
  wire [31:0] warnStart = (tPws > tOff) ? 32'h00000000 : tOff - tPws; // R10 R11
  wire [32:0] warnEnd   = {1'b0, warnStart} + {1'b0, tPwl};

  //////////////////////////////////////////////////////////////////////////////
  // trigger and event detection

  // previous levels reset low like the idle pins, so reset gives no false edge
  wire trigRise = trigLvl && !trigPrev_r;
  wire pwrRise  = (pwrLvl && !pwrPrev_r) || cmdPwr;

  // state loss only on power return without retentivity
  // a retentive block rides through a power return with state and time kept
  wire pwrLoss  = pwrRise && !retain; // R12
  // the clear pin and command win over any trigger in the same clock
  wire clearEvt = clearLvl || cmdClear || pwrLoss; // R7 R12

  // time base advance, saturating so a stalled delay never restarts at zero;
  // the prescaler runs free, so the first tick after a trigger comes one to
  // divisor+1 clocks later and on times vary by up to one tick
  wire [31:0] elapsedInc = (elapsed_r == 32'hFFFFFFFF) ? elapsed_r
                                                        : elapsed_r + 32'h00000001;

  //////////////////////////////////////////////////////////////////////////////
  // switch sequence

  // hold reached, compared before the tick is added
  wire holdReach = (elapsed_r >= tHold); // R2 R9

  // end of the off delay: already passed (a value shrunk at run time) or
  // reached by this tick, so the output falls on the tick that hits it
  wire offPassed = (elapsed_r >= tOff);  // R4 R8
  wire offReach  = (elapsedInc >= tOff); // R4 R8

  // four states: idle with the output off, holding while the trigger is
  // still pressed, delay after an early release, and continuous light;
  // the clear pin, the clear command and a power loss without retention
  // take priority over the trigger, so a held clear keeps the block idle;
  // the elapsed time counts only while holding or in the delay and reads
  // zero in the other two states
  // next state and elapsed time
  always_comb begin
    state_nxt   = state_r;
    elapsed_nxt = elapsed_r;
    if (clearEvt) begin
      state_nxt   = msw_pkg::ST_IDLE; // R7
      elapsed_nxt = 32'h00000000; // R7
    end else begin
      unique case (state_r)
        msw_pkg::ST_IDLE: begin
          elapsed_nxt = 32'h00000000; // R14
          if (trigRise) begin
            state_nxt = msw_pkg::ST_HOLDING; // R1
          end
        end
        msw_pkg::ST_HOLDING: begin
          if (!trigLvl) begin
            state_nxt = msw_pkg::ST_DELAY; // R3
            if (tick) begin
              elapsed_nxt = elapsedInc; // R3 R14
            end
          end else if (holdReach) begin
            state_nxt   = msw_pkg::ST_CONT; // R2 R9
            elapsed_nxt = 32'h00000000;
          end else if (tick) begin
            elapsed_nxt = elapsedInc; // R14
          end
        end
        msw_pkg::ST_DELAY: begin
          if (trigRise) begin
            state_nxt   = msw_pkg::ST_IDLE; // R6
            elapsed_nxt = 32'h00000000; // R6
          end else if (offPassed) begin
            state_nxt   = msw_pkg::ST_IDLE; // R4 R8
            elapsed_nxt = 32'h00000000;
          end else if (tick) begin
            elapsed_nxt = elapsedInc; // R3 R14
            if (offReach) begin
              state_nxt   = msw_pkg::ST_IDLE; // R4
              elapsed_nxt = 32'h00000000;
            end
          end
        end
        msw_pkg::ST_CONT: begin
          elapsed_nxt = 32'h00000000; // R14
          if (trigRise) begin
            state_nxt = msw_pkg::ST_IDLE; // R6
          end
        end
      endcase
    end
  end

  // pre-warning judged on the next elapsed time, so the dip starts and ends
  // on the edge of the tick that crosses its bounds and lasts whole ticks;
  // a window that reaches the off delay merges into the final off
  wire warnNxt = pwEn && (state_nxt == msw_pkg::ST_DELAY) &&
                 (elapsed_nxt >= warnStart) &&
                 ({1'b0, elapsed_nxt} < warnEnd); // R5

  // output level follows the next state
  wire swOutNxt = (state_nxt == msw_pkg::ST_HOLDING) ||
                  (state_nxt == msw_pkg::ST_CONT) ||
                  ((state_nxt == msw_pkg::ST_DELAY) && !warnNxt); // R1 R4 R5

  // sequence registers
  // contMode follows the next state so it changes on the same edge as swOut
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r     <= msw_pkg::ST_IDLE;
      elapsed_r   <= 32'h00000000;
      trigPrev_r  <= 1'b0;
      pwrPrev_r   <= 1'b0;
      swOut_r     <= 1'b0;
      contMode_r  <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      elapsed_r   <= elapsed_nxt;
      trigPrev_r  <= trigLvl;
      pwrPrev_r   <= pwrLvl;
      swOut_r     <= swOutNxt;
      contMode_r  <= (state_nxt == msw_pkg::ST_CONT);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register writes

  // configuration registers, taken when waitrequest is low
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_r     <= msw_pkg::CTRL_RST;
      offDelay_r <= msw_pkg::OFF_DELAY_RST;
      hold_r     <= msw_pkg::HOLD_RST;
      pwStart_r  <= msw_pkg::PW_START_RST;
      pwLen_r    <= msw_pkg::PW_LEN_RST;
      tickDiv_r  <= TICK_DIV_INIT;
    end else begin
      if (wrCtrl) ctrl_r <= ctrlWr;
      if (wrOff)  offDelay_r <= offWr;
      if (wrHold) hold_r <= holdWr;
      if (wrPws)  pwStart_r <= pwsWr;
      if (wrPwl)  pwLen_r <= pwlWr;
      if (wrDiv)  tickDiv_r <= divWr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register reads

  // status flags, each from registered state
  wire statHold  = (state_r == msw_pkg::ST_HOLDING);
  wire statDelay = (state_r == msw_pkg::ST_DELAY);
  wire statWarn  = pwEn && statDelay && !swOut_r;
  wire statCont  = contMode_r;
  wire statOut   = swOut_r;

  // live status of the sequence
  wire [31:0] statusWord = {27'h0000000,
                            statHold, statWarn, statDelay, statCont, statOut};

  // read mux, unmapped offsets and the command word read as zero
  // the result is registered while waitrequest is high, so it stands at the ack edge
  wire [31:0] readMux = selCtrl ? ctrl_r     :
                        selOff  ? offDelay_r :
                        selHold ? hold_r     :
                        selPws  ? pwStart_r  :
                        selPwl  ? pwLen_r    :
                        selDiv  ? tickDiv_r  :
                        selStat ? statusWord :
                        selElap ? elapsed_r  :
                        32'h00000000;

  // one wait cycle per access, read data registered meanwhile
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      waitReq_r  <= 1'b1;
      readData_r <= 32'h00000000;
    end else begin
      waitReq_r  <= !((avs_read || avs_write) && waitReq_r);
      readData_r <= readMux;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, each straight from a flip-flop so the pins never glitch

  assign avs_readdata    = readData_r;
  assign avs_waitrequest = waitReq_r;
  assign swOut           = swOut_r;
  assign contMode        = contMode_r;

endmodule : msw_light_switch
`default_nettype wire

// File: msw_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// shared constants and types of the multi-function light switch
package msw_pkg;

  // register byte offsets on the avalon slave
  localparam logic [5:0] OFF_CTRL      = 6'h00;
  localparam logic [5:0] OFF_OFF_DELAY = 6'h04;
  localparam logic [5:0] OFF_HOLD      = 6'h08;
  localparam logic [5:0] OFF_PW_START  = 6'h0C;
  localparam logic [5:0] OFF_PW_LEN    = 6'h10;
  localparam logic [5:0] OFF_TICK_DIV  = 6'h14;
  localparam logic [5:0] OFF_STATUS    = 6'h18;
  localparam logic [5:0] OFF_ELAPSED   = 6'h1C;
  localparam logic [5:0] OFF_CMD       = 6'h20;

  // control field positions
  localparam int CTRL_PW_EN   = 0;
  localparam int CTRL_RETAIN  = 1;
  localparam int CTRL_SRC_OFF = 4;
  localparam int CTRL_SRC_HLD = 5;
  localparam int CTRL_SRC_PWS = 6;
  localparam int CTRL_SRC_PWL = 7;

  // command field positions (write-only pulses)
  localparam int CMD_CLEAR   = 0;
  localparam int CMD_PWR_RET = 1;

  // status field positions
  localparam int STAT_OUT   = 0;
  localparam int STAT_CONT  = 1;
  localparam int STAT_DELAY = 2;
  localparam int STAT_WARN  = 3;
  localparam int STAT_HOLD  = 4;

  // values after reset
  localparam logic [31:0] CTRL_RST      = 32'h00000000;
  localparam logic [31:0] OFF_DELAY_RST = 32'h0000000A;
  localparam logic [31:0] HOLD_RST      = 32'h00000005;
  localparam logic [31:0] PW_START_RST  = 32'h00000002;
  localparam logic [31:0] PW_LEN_RST    = 32'h00000001;

  // time base: one tick per millisecond at a 200 MHz clock
  localparam int          CLK_KHZ      = 200000;
  localparam int          TICK_MS      = 1;
  localparam logic [31:0] TICK_DIV_RST = 32'(CLK_KHZ * TICK_MS - 1);

  // timing values as one carrier: off delay, hold, warn start, warn length
  typedef struct packed {
    logic [31:0] offDelay;
    logic [31:0] hold;
    logic [31:0] pwStart;
    logic [31:0] pwLen;
  } msw_times_s;

  // switch sequence states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HOLDING,
    ST_DELAY,
    ST_CONT
  } msw_state_e;

endpackage : msw_pkg

// File: msw_sync.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// two-flop synchroniser for asynchronous pins, one per bit
module msw_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // pins and synchronised levels
  input  wire logic [WIDTH-1:0] pinAsync,
  output logic      [WIDTH-1:0] pinSync
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_r;
      logic stable_r;
      // first flop feeds only the second
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          meta_r   <= 1'b0;
          stable_r <= 1'b0;
        end else begin
          meta_r   <= pinAsync[i];
          stable_r <= meta_r;
        end
      end
      assign pinSync[i] = stable_r;
    end
  endgenerate

endmodule : msw_sync
`default_nettype wire

// File: msw_tick.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// time base prescaler: one-cycle tick every divisor+1 clocks
module msw_tick (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // divisor and tick
  input  wire logic [31:0] divisor,
  output logic             tick
);

  logic [31:0] count_r;
  logic        tick_r;
  wire         wrap = (count_r >= divisor);

  // free-running count, wraps at the divisor
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_r <= 32'h00000000;
      tick_r  <= 1'b0;
    end else begin
      count_r <= wrap ? 32'h00000000 : count_r + 32'h00000001;
      tick_r  <= wrap;
    end
  end

  assign tick = tick_r;

endmodule : msw_tick
`default_nettype wire

// File: msw_trig_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// wall switch: presses the trigger for a commanded number of clocks
module msw_trig_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // command from the bench
  input  wire logic       go,
  input  wire logic [7:0] len,
  // trigger line, pulled low when released
  output logic            trigPin
);
  logic [7:0] cnt_r;
  // count the press down, a new press only when released
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_r   <= 8'h00;
      trigPin <= 1'b0;
    end else if (go && cnt_r == 8'h00) begin
      cnt_r   <= len;
      trigPin <= 1'b1;
    end else begin
      cnt_r   <= (cnt_r > 8'h01) ? cnt_r - 8'h01 : 8'h00;
      trigPin <= cnt_r > 8'h01;
    end
  end
endmodule : msw_trig_model
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module tb_top;
  localparam int T = 4; // clocks per tick
  logic                clk;
  logic                reset_n;
  logic [5:0]          adr;
  logic                rdEn;
  logic                wrEn;
  logic [31:0]         wdat;
  logic [31:0]         rdat;
  logic                waitReq;
  logic                trigPin;
  logic                clearPin;
  logic                pwrPin;
  logic                go;
  logic [7:0]          plen;
  logic                swOut;
  logic                contMode;
  msw_pkg::msw_times_s ext;
  logic [31:0]         d;
  int                  mismatches;
  int                  nChecks;
  int                  n;
  int                  b;
  int                  c;
  int                  dly;
  logic [31:0]         vals [8] = '{msw_pkg::CTRL_RST, msw_pkg::OFF_DELAY_RST,
    msw_pkg::HOLD_RST, msw_pkg::PW_START_RST, msw_pkg::PW_LEN_RST, 32'h3, 32'h0, 32'h0};

  // design, switch model and clock
  msw_light_switch #(.TICK_DIV_INIT(32'h3)) i_dut (.clk, .reset_n, .avs_address(adr),
    .avs_read(rdEn), .avs_write(wrEn), .avs_writedata(wdat), .avs_byteenable(4'hF),
    .avs_readdata(rdat), .avs_waitrequest(waitReq), .trigPin, .clearPin,
    .powerRestorePin(pwrPin), .extTimes(ext), .swOut, .contMode);
  msw_trig_model i_sw (.clk, .reset_n, .go, .len(plen), .trigPin);
  always #2.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    nChecks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t ns: %s", $time, m);
    end
  endtask : chk
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] v);
    @(posedge clk);
    adr  <= a;
    wdat <= v;
    wrEn <= w;
    rdEn <= !w;
    do begin
      @(posedge clk);
    end while (waitReq !== 1'b0);
    d = rdat;
    wrEn <= 1'b0;
    rdEn <= 1'b0;
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask : wr
  task automatic fire(input int len);
    @(posedge clk);
    go   <= 1'b1;
    plen <= 8'(len);
    @(posedge clk);
    go <= 1'b0;
  endtask : fire
  // cycles while the output stays at one level
  task automatic lvl(input logic v, output int k);
    k = 0;
    while (swOut === v && k < 3000) begin
      @(posedge clk);
      k++;
    end
  endtask : lvl
  task automatic hiTime(input int len, output int k);
    fire(len);
    lvl(1'b0, k);
    lvl(1'b1, k);
  endtask : hiTime
  // on time of a timed pulse, tick phase unknown
  function automatic logic inWin(input int k, input int dl);
    return k >= (dl - 1) * T && k <= dl * T + 2;
  endfunction : inWin
  task automatic report_and_stop;
    if (mismatches == 0 && nChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end
  // main sequence
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    {adr, rdEn, wrEn, wdat, clearPin, pwrPin, go, plen} = '0;
    ext = '0;
    mismatches = 0;
    nChecks = 0;
    void'($urandom(61814));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    // values after reset, command and unmapped places read zero
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, (i < 6) ? 6'(i * 4) : 6'(i * 4 + 8), 32'h0);
      chk(d === vals[i], "reset value");
    end
    // timed pulses, random off delay, one at the shortest delay
    for (int i = 0; i < 4; i++) begin
      dly = i ? 4 + $urandom % 5 : 1;
      wr(msw_pkg::OFF_OFF_DELAY, 32'(dly));
      hiTime(i ? 2 + $urandom % (dly + 4) : 2, n);
      chk(inWin(n, dly), "off delay");
    end
    // pre-warning dip and its position
    wr(msw_pkg::OFF_OFF_DELAY, 32'hA);
    wr(msw_pkg::OFF_CTRL, 32'h1);
    for (int i = 1; i < 3; i++) begin
      wr(msw_pkg::OFF_PW_START, 32'(i + 2));
      wr(msw_pkg::OFF_PW_LEN, 32'(i));
      hiTime(2, n);
      lvl(1'b0, b);
      lvl(1'b1, c);
      chk(b == i * T, "warning length");
      chk(c == 2 * T, "warning position");
    end
    // hold time, continuous light, retrigger
    wr(msw_pkg::OFF_CTRL, 32'h0);
    wr(msw_pkg::OFF_HOLD, 32'h8);
    fire(24);
    repeat (40) @(posedge clk);
    chk(contMode === 1'b0, "hold too short");
    lvl(1'b1, n);
    fire(50);
    repeat (120) @(posedge clk);
    chk(contMode === 1'b1 && swOut === 1'b1, "continuous light");
    bus(1'b0, msw_pkg::OFF_STATUS, 32'h0);
    chk(d === 32'((1 << msw_pkg::STAT_OUT) | (1 << msw_pkg::STAT_CONT)), "status");
    fire(3);
    repeat (12) @(posedge clk);
    chk(swOut === 1'b0 && contMode === 1'b0, "retrigger in continuous");
    fire(3);
    repeat (16) @(posedge clk);
    fire(3);
    repeat (12) @(posedge clk);
    chk(swOut === 1'b0, "retrigger in delay");
    // clear by pin and command, power return plain and retentive
    for (int k = 0; k < 4; k++) begin
      wr(msw_pkg::OFF_CTRL, (k == 3) ? 32'h2 : 32'h0);
      fire(3);
      repeat (16) @(posedge clk);
      if (k[0]) begin
        wr(msw_pkg::OFF_CMD, 32'(k / 2 + 1));
      end else begin
        {pwrPin, clearPin} <= 2'(1 << (k / 2));
        repeat (7) @(posedge clk);
        {pwrPin, clearPin} <= 2'b00;
      end
      repeat (8) @(posedge clk);
      bus(1'b0, msw_pkg::OFF_ELAPSED, 32'h0);
      chk(swOut === (k == 3) && (d != 32'h0) === (k == 3), "clear or power return");
      lvl(1'b1, n);
    end
    // times taken from another function
    dly = 4 + $urandom % 3;
    ext <= '{32'(dly), 32'h1, 32'h2, 32'h1};
    wr(msw_pkg::OFF_CTRL, 32'h10);
    hiTime(2, n);
    chk(inWin(n, dly), "external off delay");
    wr(msw_pkg::OFF_CTRL, 32'hD1);
    hiTime(2, n);
    lvl(1'b0, b);
    lvl(1'b1, c);
    chk(b == T && c == T, "external warning");
    wr(msw_pkg::OFF_CTRL, 32'h20);
    fire(16);
    repeat (30) @(posedge clk);
    chk(contMode === 1'b1, "external hold");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
